// ---- rtl/rtcc_sram_pkg.sv ----
// Constants for the serial access path to the timekeeping registers and user SRAM.
// Assumes one 10 MHz system clock; the serial clock and data are sampled, never used as clocks.
package rtcc_sram_pkg;

	localparam int ADDR_W = 7;
	localparam int SRAM_DEPTH = 64;
	localparam int TK_DEPTH = 32;
	localparam int SRAM_IDX_W = 6;
	localparam int TK_IDX_W = 5;
	localparam int BIT_CNT_W = 4;

	// Control byte is 1101111 followed by the direction bit
	localparam logic [6:0] CTRL_CODE = 7'h6F;

	localparam logic [6:0] TK_FIRST = 7'h00;
	localparam logic [6:0] TK_LAST = 7'h1F;
	localparam logic [6:0] SRAM_FIRST = 7'h20;
	localparam logic [6:0] SRAM_LAST = 7'h5F;
	localparam logic [7:0] ADDR_MAX = 8'h5F;

	localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;

	localparam logic [TK_IDX_W-1:0] WEEKDAY_STATUS_IDX = 5'h03;
	localparam logic [TK_IDX_W-1:0] DN_MIN_IDX = 5'h18;
	localparam logic [TK_IDX_W-1:0] DN_HOUR_IDX = 5'h19;
	localparam logic [TK_IDX_W-1:0] DN_DATE_IDX = 5'h1A;
	localparam logic [TK_IDX_W-1:0] DN_MONTH_IDX = 5'h1B;
	localparam logic [TK_IDX_W-1:0] UP_MIN_IDX = 5'h1C;
	localparam logic [TK_IDX_W-1:0] UP_HOUR_IDX = 5'h1D;
	localparam logic [TK_IDX_W-1:0] UP_DATE_IDX = 5'h1E;
	localparam logic [TK_IDX_W-1:0] UP_MONTH_IDX = 5'h1F;
	localparam logic [TK_IDX_W-1:0] STAMP_FIRST_IDX = 5'h18;

	// Weekday and supply status fields
	localparam int OSC_RUN_BIT = 5;
	localparam int PWR_FAIL_BIT = 4;
	localparam int BACKUP_EN_BIT = 3;

	// Time-stamp month fields
	localparam int WEEKDAY_MSB = 7;
	localparam int WEEKDAY_LSB = 5;
	localparam int MONTH_TENS_BIT = 4;
	localparam int MONTH_UNITS_MSB = 3;
	localparam int MONTH_UNITS_LSB = 0;

	// Implemented bits; the rest read as zero, except the oscillator-running bit of the weekday/status byte
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_MIN = 8'h7F;
	localparam logic [7:0] MASK_HOUR = 8'h7F;
	localparam logic [7:0] MASK_DATE = 8'h3F;
	localparam logic [7:0] MASK_MONTH = 8'hFF;
	localparam logic [7:0] MASK_WEEKDAY_STATUS = 8'h1F;
	localparam logic [7:0] TK_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] PTR_RESET = 7'h00;

	typedef enum logic [8:0] {
		ST_IDLE = 9'b000000001,
		ST_CTRL = 9'b000000010,
		ST_CTRL_ACK = 9'b000000100,
		ST_WORD = 9'b000001000,
		ST_WORD_ACK = 9'b000010000,
		ST_WDATA = 9'b000100000,
		ST_WDATA_ACK = 9'b001000000,
		ST_RDATA = 9'b010000000,
		ST_RACK = 9'b100000000
	} serial_state_t;

	function automatic logic [7:0] tk_mask(input logic [TK_IDX_W-1:0] idx);
		case (idx)
			DN_MIN_IDX, UP_MIN_IDX: tk_mask = MASK_MIN;
			DN_HOUR_IDX, UP_HOUR_IDX: tk_mask = MASK_HOUR;
			DN_DATE_IDX, UP_DATE_IDX: tk_mask = MASK_DATE;
			DN_MONTH_IDX, UP_MONTH_IDX: tk_mask = MASK_MONTH;
			WEEKDAY_STATUS_IDX: tk_mask = MASK_WEEKDAY_STATUS;
			default: tk_mask = MASK_ALL;
		endcase
	endfunction : tk_mask

	function automatic logic [ADDR_W-1:0] ptr_next(input logic [ADDR_W-1:0] p);
		if (p == TK_LAST)
			ptr_next = TK_FIRST;
		else if (p == SRAM_LAST)
			ptr_next = SRAM_FIRST;
		else
			ptr_next = ADDR_W'(p + 7'h01);
	endfunction : ptr_next

endpackage : rtcc_sram_pkg

// ---- rtl/rtcc_sram_serial_access.sv ----
// Serial client for the timekeeping register space and the user SRAM, with power-fail stamps.
// Assumes scl/sda and the supply status come from pins; stamp events and time are on clk.
`timescale 1ns/1ns
`default_nettype none

module rtcc_sram_serial_access
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic on_backup_supply,
	input wire logic oscillator_running_flag,
	input wire logic supply_down_event,
	input wire logic supply_up_event,
	input wire logic [7:0] now_minutes,
	input wire logic [7:0] now_hours,
	input wire logic [7:0] now_date,
	input wire logic [7:0] now_month,
	output logic power_failure_flag
);
	import rtcc_sram_pkg::*;

	logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
	logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
	logic bkp_s1_ff, bkp_s2_ff;
	serial_state_t state_ff;
	logic [BIT_CNT_W-1:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic host_ack_ff;
	logic [ADDR_W-1:0] ptr_ff;
	logic sda_oe_ff;
	logic sda_out_ff;
	logic [7:0] tk_ff [TK_DEPTH];
	logic [7:0] sram_mem [SRAM_DEPTH];

	logic scl_rise, scl_fall, bus_start, bus_stop;
	logic byte_done, wr_go;
	logic [7:0] rd_byte;
	logic [SRAM_IDX_W-1:0] sram_idx;
	logic [TK_IDX_W-1:0] tk_idx;
	logic flag_now, flag_clear;

	// Pins pass two flops; the third stage only keeps history for edges
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_s3_ff <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_s3_ff <= 1'b1;
			bkp_s1_ff <= 1'b0;
			bkp_s2_ff <= 1'b0;
		end
		else
		begin
			scl_s1_ff <= scl_in;
			scl_s2_ff <= scl_s1_ff;
			scl_s3_ff <= scl_s2_ff;
			sda_s1_ff <= sda_in;
			sda_s2_ff <= sda_s1_ff;
			sda_s3_ff <= sda_s2_ff;
			bkp_s1_ff <= on_backup_supply;
			bkp_s2_ff <= bkp_s1_ff;
		end
	end

	always_comb
	begin
		scl_rise = scl_s2_ff & ~scl_s3_ff;
		scl_fall = ~scl_s2_ff & scl_s3_ff;
		bus_start = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
		bus_stop = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
		byte_done = scl_fall && (bit_cnt_ff == BITS_PER_BYTE);
		wr_go = (state_ff == ST_WDATA) && byte_done && !bkp_s2_ff;
		sram_idx = SRAM_IDX_W'(ptr_ff - SRAM_FIRST);
		tk_idx = ptr_ff[TK_IDX_W-1:0];
		flag_now = tk_ff[WEEKDAY_STATUS_IDX][PWR_FAIL_BIT];
		flag_clear = wr_go && (tk_idx == WEEKDAY_STATUS_IDX) && (ptr_ff <= TK_LAST)
			&& !shift_ff[PWR_FAIL_BIT];
	end

	// Read path; no update interlock, so either block answers at any time
	always_comb
	begin
		if (ptr_ff >= SRAM_FIRST)
			rd_byte = sram_mem[sram_idx];
		else if (tk_idx == WEEKDAY_STATUS_IDX)
		begin
			rd_byte = tk_ff[tk_idx];
			rd_byte[OSC_RUN_BIT] = oscillator_running_flag;
		end
		else
			rd_byte = tk_ff[tk_idx];
	end

	// Serial protocol engine
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_ff <= ST_IDLE;
			bit_cnt_ff <= '0;
			shift_ff <= '0;
			tx_ff <= '0;
			host_ack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end
		else if (bkp_s2_ff)
		begin
			state_ff <= ST_IDLE;
			sda_oe_ff <= 1'b0;
		end
		else if (bus_start)
		begin
			state_ff <= ST_CTRL;
			bit_cnt_ff <= '0;
			sda_oe_ff <= 1'b0;
		end
		else if (bus_stop)
		begin
			state_ff <= ST_IDLE;
			sda_oe_ff <= 1'b0;
		end
		else
		begin
			case (state_ff)
				ST_IDLE:
				begin
					sda_oe_ff <= 1'b0;
				end
				ST_CTRL, ST_WORD, ST_WDATA:
				begin
					if (scl_rise)
					begin
						shift_ff <= {shift_ff[6:0], sda_s2_ff};
						bit_cnt_ff <= BIT_CNT_W'(bit_cnt_ff + 4'h1);
					end
					else if (byte_done)
					begin
						bit_cnt_ff <= '0;
						if (state_ff == ST_CTRL)
						begin
							if (shift_ff[7:1] == CTRL_CODE)
							begin
								sda_oe_ff <= 1'b1;
								state_ff <= ST_CTRL_ACK;
							end
							else
								state_ff <= ST_IDLE;
						end
						else if (state_ff == ST_WORD)
						begin
							if (shift_ff <= ADDR_MAX)
							begin
								sda_oe_ff <= 1'b1;
								state_ff <= ST_WORD_ACK;
							end
							else
								state_ff <= ST_IDLE;
						end
						else
						begin
							sda_oe_ff <= 1'b1;
							state_ff <= ST_WDATA_ACK;
						end
					end
				end
				ST_CTRL_ACK:
				begin
					if (scl_fall)
					begin
						if (shift_ff[0])
						begin
							tx_ff <= {rd_byte[6:0], 1'b0};
							sda_oe_ff <= ~rd_byte[7];
							bit_cnt_ff <= 4'h1;
							state_ff <= ST_RDATA;
						end
						else
						begin
							sda_oe_ff <= 1'b0;
							bit_cnt_ff <= '0;
							state_ff <= ST_WORD;
						end
					end
				end
				ST_WORD_ACK, ST_WDATA_ACK:
				begin
					if (scl_fall)
					begin
						sda_oe_ff <= 1'b0;
						bit_cnt_ff <= '0;
						state_ff <= ST_WDATA;
					end
				end
				ST_RDATA:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_ff == BITS_PER_BYTE)
						begin
							sda_oe_ff <= 1'b0;
							host_ack_ff <= 1'b0;
							state_ff <= ST_RACK;
						end
						else
						begin
							sda_oe_ff <= ~tx_ff[7];
							tx_ff <= {tx_ff[6:0], 1'b0};
							bit_cnt_ff <= BIT_CNT_W'(bit_cnt_ff + 4'h1);
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise)
						host_ack_ff <= ~sda_s2_ff;
					else if (scl_fall)
					begin
						if (host_ack_ff)
						begin
							tx_ff <= {rd_byte[6:0], 1'b0};
							sda_oe_ff <= ~rd_byte[7];
							bit_cnt_ff <= 4'h1;
							state_ff <= ST_RDATA;
						end
						else
							state_ff <= ST_IDLE;
					end
				end
				default:
				begin
					state_ff <= ST_IDLE;
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// Address pointer survives between transfers for current-address reads
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ptr_ff <= PTR_RESET;
		else if (!bkp_s2_ff && !bus_start && !bus_stop)
		begin
			if ((state_ff == ST_WORD) && byte_done && (shift_ff <= ADDR_MAX))
				ptr_ff <= ADDR_W'(shift_ff);
			else if (wr_go)
				ptr_ff <= ptr_next(ptr_ff);
			else if ((state_ff == ST_RDATA) && byte_done)
				ptr_ff <= ptr_next(ptr_ff);
		end
	end

	// SRAM has no reset so its contents survive a power-on reset
	always_ff @(posedge clk)
	begin
		if (wr_go && (ptr_ff >= SRAM_FIRST))
			sram_mem[sram_idx] <= shift_ff;
	end

	// Timekeeping bytes, stamp capture and the power-failure flag
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < TK_DEPTH; i++)
				tk_ff[i] <= TK_RESET;
		end
		else
		begin
			if (wr_go && (ptr_ff <= TK_LAST))
				tk_ff[tk_idx] <= shift_ff & tk_mask(tk_idx);
			if (flag_clear)
			begin
				for (int i = STAMP_FIRST_IDX; i < TK_DEPTH; i++)
					tk_ff[i] <= TK_RESET;
			end
			// Capture after the clear; a same-cycle event is kept only if the flag was already clear
			if (supply_down_event && !flag_now)
			begin
				tk_ff[DN_MIN_IDX] <= now_minutes & MASK_MIN;
				tk_ff[DN_HOUR_IDX] <= now_hours & MASK_HOUR;
				tk_ff[DN_DATE_IDX] <= now_date & MASK_DATE;
				tk_ff[DN_MONTH_IDX] <= now_month & MASK_MONTH;
			end
			if (supply_up_event && !flag_now)
			begin
				tk_ff[UP_MIN_IDX] <= now_minutes & MASK_MIN;
				tk_ff[UP_HOUR_IDX] <= now_hours & MASK_HOUR;
				tk_ff[UP_DATE_IDX] <= now_date & MASK_DATE;
				tk_ff[UP_MONTH_IDX] <= now_month & MASK_MONTH;
				tk_ff[WEEKDAY_STATUS_IDX][PWR_FAIL_BIT] <= 1'b1;
			end
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			sda_out_ff <= 1'b0;
		else
			sda_out_ff <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			power_failure_flag <= 1'b0;
		else
			power_failure_flag <= flag_now;
	end

	assign sda_out = sda_out_ff;
	assign sda_oe = sda_oe_ff;

endmodule : rtcc_sram_serial_access

`default_nettype wire

// ---- dv/rtcc_sram_serial_access_sva.sv ----
// Checker on the serial access block's pins and failure flag.
// Assumes the host holds each SCL phase for at least eight clocks.
`timescale 1ns/1ns
`default_nettype none

module rtcc_sram_sva
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic on_backup_supply,
	input wire logic supply_up_event,
	input wire logic power_failure_flag
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Start seen on the raw pins, SCL high on both samples
	sequence start_seen;
		$past(scl_in) && scl_in && $past(sda_in) && !sda_in;
	endsequence
	// Long enough for the pin synchroniser to pass it on
	sequence backup_held;
		on_backup_supply [*6];
	endsequence

	chk_drive_zero: assert property (sda_out == 1'b0)
		else $error("sda_out not low");
	chk_rst_quiet: assert property ($fell(sys_rst) |-> !sda_oe && !power_failure_flag)
		else $error("outputs not quiet after reset");
	chk_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*8])
		else $error("sda drive shorter than a bit");
	chk_oe_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
		else $error("sda drive changed while scl high");
	chk_ctrl_no_drive: assert property (start_seen |-> !sda_oe [*8])
		else $error("sda driven right after start");
	chk_backup_idle: assert property (backup_held |-> !sda_oe)
		else $error("sda driven on backup supply");
	chk_flag_set: assert property (supply_up_event && !power_failure_flag
		|-> ##[1:3] power_failure_flag)
		else $error("failure flag not set");
	chk_flag_clr_bus: assert property ($fell(power_failure_flag) |-> !scl_in)
		else $error("failure flag cleared outside a write");
endmodule : rtcc_sram_sva

bind rtcc_sram_serial_access rtcc_sram_sva chk_u (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .on_backup_supply(on_backup_supply),
	.supply_up_event(supply_up_event), .power_failure_flag(power_failure_flag));

`default_nettype wire

// ---- dv/i2c_host_model.sv ----
// Serial host: drives SCL, pulls SDA low through sda_pull.
// Assumes SDA has a pull-up, so a released line reads high.
`timescale 1ns/1ns
`default_nettype none

module i2c_host_model
(
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_pull
);
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic half();
		repeat (10) @(negedge clk);
	endtask : half

	// Data moves three clocks after SCL falls, never with it
	task automatic bit_io(input logic b, output logic seen);
		sda_pull = ~b;
		half();
		scl = 1'b1;
		half();
		seen = sda_line;
		scl = 1'b0;
		repeat (3) @(negedge clk);
	endtask : bit_io

	task automatic start_c();
		sda_pull = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_pull = 1'b1;
		half();
		scl = 1'b0;
		repeat (3) @(negedge clk);
	endtask : start_c

	task automatic stop_c();
		sda_pull = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_pull = 1'b0;
		half();
	endtask : stop_c

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wbyte

	// Host acknowledge asks for one more byte
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~more, s);
	endtask : rbyte
endmodule : i2c_host_model

`default_nettype wire

// ---- dv/rtcc_sram_serial_access_tb.sv ----
// Bench for the serial access block, driven through the host model.
// Assumes a pulled-up SDA and a 10 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module rtcc_sram_serial_access_tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic scl, pull, line, oe, sout, bk, osc, dn, up, flag, ack, ok, ef;
	logic [7:0] mn, hr, dt, mo, p, a;
	logic [7:0] mem [0:95];
	logic [7:0] wb [0:7];
	int errors = 0;
	int cmp_count = 0;

	assign line = ~(oe | pull);
	always #50 clk = ~clk;

	rtcc_sram_serial_access dut_u (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(line),
		.sda_out(sout), .sda_oe(oe), .on_backup_supply(bk), .oscillator_running_flag(osc),
		.supply_down_event(dn), .supply_up_event(up), .now_minutes(mn), .now_hours(hr),
		.now_date(dt), .now_month(mo), .power_failure_flag(flag));
	i2c_host_model host_u (.clk(clk), .sda_line(line), .scl(scl), .sda_pull(pull));

	// Pointer rolls over inside its own block
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return (v == 8'h1F) ? 8'h00 : (v == 8'h5F) ? 8'h20 : v + 8'h01;
	endfunction : nxt

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		if (errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	task automatic wr(input logic [7:0] ad, input int n);
		ok = ad <= 8'h5F;
		host_u.start_c();
		host_u.wbyte(8'hDE, ack);
		chk("ctrl ack", {7'h00, ack}, 8'h01);
		host_u.wbyte(ad, ack);
		chk("addr ack", {7'h00, ack}, {7'h00, ok});
		if (ok)
			p = ad;
		for (int i = 0; i < n; i++)
		begin
			host_u.wbyte(wb[i], ack);
			chk("data ack", {7'h00, ack}, {7'h00, ok});
			if (ok)
			begin
				mem[p] = wb[i];
				p = nxt(p);
			end
		end
		host_u.stop_c();
	endtask : wr

	task automatic rd(input logic [7:0] ad, input int n, input logic set);
		logic [7:0] d;
		if (set)
		begin
			host_u.start_c();
			host_u.wbyte(8'hDE, ack);
			host_u.wbyte(ad, ack);
			p = ad;
		end
		host_u.start_c();
		host_u.wbyte(8'hDF, ack);
		chk("read ack", {7'h00, ack}, 8'h01);
		for (int i = 0; i < n; i++)
		begin
			host_u.rbyte(i < n - 1, d);
			chk("read data", d, mem[p]);
			p = nxt(p);
		end
		host_u.stop_c();
	endtask : rd

	// Expected stamp follows the bench's own copy of the flag
	task automatic pulse(input logic is_up);
		logic [7:0] b;
		b = is_up ? 8'h1C : 8'h18;
		mn = $urandom;
		hr = $urandom;
		dt = $urandom;
		mo = $urandom;
		if (!ef)
		begin
			mem[b] = mn & 8'h7F;
			mem[b + 8'h01] = hr & 8'h7F;
			mem[b + 8'h02] = dt & 8'h3F;
			mem[b + 8'h03] = mo;
		end
		ef = ef | is_up;
		dn = ~is_up;
		up = is_up;
		@(negedge clk);
		dn = 1'b0;
		up = 1'b0;
		repeat (4) @(negedge clk);
	endtask : pulse

	initial
	begin
		{bk, dn, up, ef, mn, hr, dt, mo} = '0;
		void'($urandom(39257));
		osc = $urandom;
		for (int i = 0; i < 32; i++)
			mem[i] = 8'h00;
		repeat (12) @(negedge clk);
		sys_rst = 1'b0;
		repeat (6) @(negedge clk);
		rd(8'h1B, 1, 1'b1);
		rd(8'h1F, 1, 1'b1);
		wb[0] = {3'($urandom_range(7, 1)), 1'b1, 4'($urandom_range(9))};
		wb[1] = $urandom;
		wr(8'h1F, 2);
		rd(8'h00, 1, 1'b0);
		rd(8'h1F, 2, 1'b1);
		wb[0] = $urandom;
		wr(8'h1B, 1);
		rd(8'h00, 1, 1'b0);
		for (int i = 0; i < 5; i++)
			wb[i] = $urandom;
		wr(8'h5E, 5);
		rd(8'h5F, 3, 1'b1);
		rd(8'h00, 1, 1'b0);
		for (int k = 0; k < 6; k++)
		begin
			a = 8'h20 + 8'($urandom_range(63));
			wb[0] = $urandom;
			wr(a, 1);
			rd(a, 1, 1'b1);
		end
		rd(8'h1F, 1, 1'b1);
		wr(8'h60 + 8'($urandom_range(159)), 1);
		rd(8'h00, 1, 1'b0);
		host_u.start_c();
		host_u.wbyte(8'hA0 | 8'($urandom_range(1)), ack);
		chk("bad ctrl ack", {7'h00, ack}, 8'h00);
		host_u.stop_c();
		bk = 1'b1;
		repeat (8) @(negedge clk);
		host_u.start_c();
		host_u.wbyte(8'hDE, ack);
		chk("backup ack", {7'h00, ack}, 8'h00);
		host_u.stop_c();
		bk = 1'b0;
		repeat (8) @(negedge clk);
		pulse(1'b0);
		pulse(1'b1);
		pulse(1'b0);
		chk("flag set", {7'h00, flag}, 8'h01);
		mem[8'h03] = {2'b00, osc, 5'h10};
		rd(8'h03, 1, 1'b1);
		rd(8'h18, 8, 1'b1);
		wb[0] = 8'h00;
		wr(8'h03, 1);
		for (int i = 24; i < 32; i++)
			mem[i] = 8'h00;
		chk("flag clear", {7'h00, flag}, 8'h00);
		rd(8'h18, 8, 1'b1);
		end_of_test();
	end
endmodule : rtcc_sram_serial_access_tb

`default_nettype wire
